//--- rtl/psq_pkg.sv
/*
 * Package for the program sequencer and table read block.
 * Assumes a 32-bit APB register bus and a 14-bit program store.
 */
package psq_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PC_W       = 10;
    localparam int WORD_W     = 14;
    localparam int ROM_DEPTH  = 1024;
    localparam int PHASES     = 4;

    // ------------------------------------------------------------
    // Register offsets (byte addresses are four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PCL      = 8'h06;
    localparam logic [7:0] IDX_TPTR     = 8'h07;
    localparam logic [7:0] IDX_THB      = 8'h08;
    localparam logic [7:0] IDX_CTRL     = 8'h10;
    localparam logic [7:0] IDX_STAT     = 8'h11;
    localparam logic [7:0] IDX_TDATA    = 8'h12;
    localparam logic [7:0] IDX_PROG     = 8'h13;

    // ------------------------------------------------------------
    // Vectors and limits
    // ------------------------------------------------------------
    localparam logic [9:0] VEC_RESET    = 10'h000;
    localparam logic [9:0] VEC_EXT      = 10'h004;
    localparam logic [9:0] VEC_TMR      = 10'h008;
    localparam logic [1:0] LAST_PAGE    = 2'h3;
    localparam logic [1:0] PH_LAST      = 2'h3;
    localparam logic [1:0] STACK_LEVELS = 2'h2;

    // Control register fields
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_EXTE = 1;
    localparam int CTRL_TMRE = 2;

    // ------------------------------------------------------------
    // Instruction classes from the decoder
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_JUMP   = 3'b001,
        OP_CALL   = 3'b010,
        OP_RET    = 3'b011,
        OP_SKIP   = 3'b100,
        OP_TRDC   = 3'b101,
        OP_TRDL   = 3'b110,
        OP_PCLWR  = 3'b111
    } psq_op_type;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_DUMMY = 2'b01,
        ST_TABLE = 2'b10
    } psq_state_type;

    typedef struct packed {
        psq_op_type       op;
        logic [PC_W-1:0]  target;
        logic             skip_true;
        logic [7:0]       pcl_data;
    } psq_dec_type;

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } psq_apb_req_type;

endpackage : psq_pkg

//--- rtl/psq_sequencer.sv
/*
 * Program sequencer: phase divider, fetch/execute pipeline, program
 * counter, vectors, two-level stack and table reads, with APB registers.
 * Assumes the decoder presents a decoded class for the word in the
 * instruction register, held stable through an instruction cycle.
 */
// Chosen here: register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE_01] Four clock phases make one instruction cycle of four clocks.
// [RULE_02] Fetch of the next word overlaps execution of the current one.
// [RULE_03] Counter-changing instructions take two cycles, one a dummy.
// [RULE_04] Counter advances by one after each instruction fetch.
// [RULE_05] True skip swaps fetched word for a dummy; counter gains two.
// [RULE_06] Low byte write replaces counter bits 7..0, keeps bits 9..8.
// [RULE_07] Reset clears the counter to address zero.
// [RULE_08] Enabled external interrupt with stack room loads vector four.
// [RULE_09] Enabled timer overflow with stack room loads vector eight.
// [RULE_10] Jumps take all ten bits from code; returns take top stack entry.
// [RULE_11] Program store is 1024 words of 14 bits.
// [RULE_12] Current-page table read uses counter page with pointer low bits.
// [RULE_13] Table read low byte to data, six high bits to high byte register.
// [RULE_14] High byte register is read only; writes are ignored.
// [RULE_15] Software loads the table pointer before a table read.
// [RULE_16] Every table read takes two instruction cycles.
// [RULE_17] Software disables interrupts around shared table reads.
// [RULE_18] Last-page table read forces address bits 9..8 to one.
// [RULE_19] Full stack keeps interrupt pending until a return pops.
// [RULE_20] Ten-bit counter wraps within the 1024-word space.
module psq_sequencer #(
    parameter int DEPTH = psq_pkg::ROM_DEPTH
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic [31:0]                 paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire psq_pkg::psq_dec_type        dec,
    input  wire logic                        ext_irq,
    input  wire logic                        tmr_irq,
    output logic      [psq_pkg::WORD_W-1:0]  instr_word,
    output logic                             exec_valid,
    output logic      [7:0]                  tbl_data,
    output logic                             tbl_data_valid,
    output logic      [1:0]                  phase
);
    import psq_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]          ph;
        psq_state_type       st;
        logic [PC_W-1:0]     pc;
        logic [WORD_W-1:0]   ir;
        logic                ir_valid;
        logic [PC_W-1:0]     stk0;
        logic [PC_W-1:0]     stk1;
        logic [1:0]          depth;
        logic [7:0]          tptr;
        logic [5:0]          thb;
        logic [7:0]          tdata;
        logic                tvalid;
        logic                ext_pend;
        logic                tmr_pend;
        logic [2:0]          ctrl;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic [PC_W-1:0]     prog_addr;
    } psq_regs_type;

    psq_regs_type q_r;
    psq_regs_type q_nxt;

    // Program store; loaded by software, since there is no image file
    logic [WORD_W-1:0] rom [DEPTH];                          // [RULE_11]
    logic              rom_we;
    logic [PC_W-1:0]   tbl_addr;
    logic [WORD_W-1:0] tbl_word;
    logic [7:0]        idx;
    logic              acc;

    assign idx = paddr[9:2];
    assign acc = psel && penable && !q_r.pready;

    always_ff @(posedge pclk) begin
        if (rom_we) begin
            rom[q_r.prog_addr] <= pwdata[WORD_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic             cyc_end;
        logic             room;
        logic [PC_W-1:0]  pc_inc;
        q_nxt    = q_r;
        cyc_end  = 1'b0;
        room     = 1'b0;
        pc_inc   = '0;
        rom_we   = 1'b0;
        tbl_addr = '0;
        tbl_word = '0;

        // Events latch until serviced; a set is never lost
        if (ext_irq) q_nxt.ext_pend = 1'b1;
        if (tmr_irq) q_nxt.tmr_pend = 1'b1;

        q_nxt.tvalid = 1'b0;
        if (q_r.ctrl[CTRL_RUN]) begin
            q_nxt.ph = q_r.ph + 2'h1;                        // [RULE_01]
            cyc_end  = (q_r.ph == PH_LAST);
        end
        pc_inc = q_r.pc + 10'h001;                           // [RULE_20]
        room   = (q_r.depth < STACK_LEVELS);

        if (cyc_end) begin
            case (q_r.st)
                ST_FETCH: begin
                    // Execute held word while fetching the next  [RULE_02]
                    q_nxt.ir       = rom[q_r.pc];
                    q_nxt.ir_valid = 1'b1;
                    q_nxt.pc       = pc_inc;                 // [RULE_04]
                    if (q_r.ir_valid) begin
                        case (dec.op)
                            OP_JUMP: begin
                                q_nxt.pc = dec.target;       // [RULE_10]
                                q_nxt.st = ST_DUMMY;         // [RULE_03]
                            end
                            OP_CALL: begin
                                q_nxt.stk1 = q_r.stk0;
                                q_nxt.stk0 = q_r.pc;
                                if (room) begin
                                    q_nxt.depth = q_r.depth + 2'h1;
                                end
                                q_nxt.pc = dec.target;       // [RULE_10]
                                q_nxt.st = ST_DUMMY;
                            end
                            OP_RET: begin
                                q_nxt.pc   = q_r.stk0;       // [RULE_10]
                                q_nxt.stk0 = q_r.stk1;
                                if (q_r.depth != 2'h0) begin
                                    q_nxt.depth = q_r.depth - 2'h1;
                                end
                                q_nxt.st = ST_DUMMY;
                            end
                            OP_SKIP: begin
                                if (dec.skip_true) begin
                                    q_nxt.st = ST_DUMMY;     // [RULE_05]
                                end
                            end
                            OP_PCLWR: begin
                                q_nxt.pc = {q_r.pc[9:8],
                                            dec.pcl_data};   // [RULE_06]
                                q_nxt.st = ST_DUMMY;
                            end
                            OP_TRDC, OP_TRDL: begin
                                // Table op stays decoded for its slot
                                q_nxt.ir = q_r.ir;
                                q_nxt.pc = q_r.pc;
                                q_nxt.st = ST_TABLE;         // [RULE_16]
                            end
                            default: begin
                            end
                        endcase
                        // Interrupts only after plain instructions;
                        // return lands on the dropped prefetch word
                        if (dec.op == OP_NONE && room) begin // [RULE_19]
                            if (q_r.ext_pend && q_r.ctrl[CTRL_EXTE]) begin
                                q_nxt.ext_pend = ext_irq;
                                q_nxt.stk1  = q_r.stk0;
                                q_nxt.stk0  = q_r.pc;
                                q_nxt.depth = q_r.depth + 2'h1;
                                q_nxt.pc    = VEC_EXT;       // [RULE_08]
                                q_nxt.st    = ST_DUMMY;
                            end else if (q_r.tmr_pend &&
                                         q_r.ctrl[CTRL_TMRE]) begin
                                q_nxt.tmr_pend = tmr_irq;
                                q_nxt.stk1  = q_r.stk0;
                                q_nxt.stk0  = q_r.pc;
                                q_nxt.depth = q_r.depth + 2'h1;
                                q_nxt.pc    = VEC_TMR;       // [RULE_09]
                                q_nxt.st    = ST_DUMMY;
                            end
                        end
                        // Prefetched word must not execute in the slot
                        if (q_nxt.st != ST_FETCH) begin
                            q_nxt.ir_valid = 1'b0;           // [RULE_03]
                        end
                    end
                end
                ST_DUMMY, ST_TABLE: begin
                    if (q_r.st == ST_TABLE) begin
                        if (dec.op == OP_TRDL) begin
                            tbl_addr = {LAST_PAGE, q_r.tptr};    // [RULE_18]
                        end else begin
                            tbl_addr = {q_r.pc[9:8], q_r.tptr};  // [RULE_12]
                        end
                        tbl_word     = rom[tbl_addr];
                        q_nxt.tdata  = tbl_word[7:0];        // [RULE_13]
                        q_nxt.thb    = tbl_word[WORD_W-1:8]; // [RULE_13]
                        q_nxt.tvalid = 1'b1;
                    end
                    // Refill the pipe from the counter      [RULE_03]
                    q_nxt.ir       = rom[q_r.pc];
                    q_nxt.ir_valid = 1'b1;
                    q_nxt.pc       = pc_inc;
                    q_nxt.st       = ST_FETCH;               // [RULE_16]
                end
                default: begin
                    q_nxt.st = ST_FETCH;
                end
            endcase
        end

        // --------------------------------------------------------
        // APB slave, one wait state
        // --------------------------------------------------------
        q_nxt.pready  = acc;
        q_nxt.pslverr = 1'b0;
        if (acc) begin
            q_nxt.prdata = 32'h0000_0000;
            case (idx)
                IDX_PCL: begin
                    q_nxt.prdata[7:0] = q_r.pc[7:0];
                end
                IDX_TPTR: begin
                    q_nxt.prdata[7:0] = q_r.tptr;            // [RULE_15]
                    if (pwrite) q_nxt.tptr = pwdata[7:0];
                end
                IDX_THB: begin
                    // Writes dropped, top two bits zero     [RULE_14]
                    q_nxt.prdata[5:0] = q_r.thb;
                end
                IDX_CTRL: begin
                    q_nxt.prdata[2:0] = q_r.ctrl;
                    if (pwrite) q_nxt.ctrl = pwdata[2:0];
                end
                IDX_STAT: begin
                    q_nxt.prdata[PC_W-1:0] = q_r.pc;
                    q_nxt.prdata[17:16]    = q_r.depth;
                    q_nxt.prdata[20]       = q_r.ext_pend;
                    q_nxt.prdata[21]       = q_r.tmr_pend;
                end
                IDX_TDATA: begin
                    q_nxt.prdata[7:0] = q_r.tdata;
                end
                IDX_PROG: begin
                    // Write stores word, then steps the load address
                    q_nxt.prdata[PC_W-1:0] = q_r.prog_addr;
                    if (pwrite) begin
                        rom_we          = 1'b1;
                        q_nxt.prog_addr = q_r.prog_addr + 10'h001;
                    end
                end
                default: begin
                    q_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r    <= '0;
            q_r.pc <= VEC_RESET;                             // [RULE_07]
            q_r.st <= ST_FETCH;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign prdata         = q_r.prdata;
    assign pready         = q_r.pready;
    assign pslverr        = q_r.pslverr;
    assign instr_word     = q_r.ir;
    assign exec_valid     = q_r.ir_valid;
    assign tbl_data       = q_r.tdata;
    assign tbl_data_valid = q_r.tvalid;
    assign phase          = q_r.ph;

endmodule : psq_sequencer

//--- tb/psq_decoder_model.sv
/*
 * Behavioural instruction decoder that stands beside the sequencer.
 * Assumes the bench's code: op in bits 13..11, skip flag in bit 10,
 * target or low byte in the bits below.
 */
`timescale 1ns/1ps
module psq_decoder_model (
    input  wire logic [13:0]           instr_word,
    output psq_pkg::psq_dec_type       dec
);
    import psq_pkg::*;
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        dec.op        = psq_op_type'(instr_word[13:11]);
        dec.target    = instr_word[9:0];
        dec.skip_true = instr_word[10];
        dec.pcl_data  = instr_word[7:0];
    end
endmodule : psq_decoder_model

//--- tb/psq_seq_monitor.sv
/*
 * Port checker for the program sequencer.
 * Assumes binding to every psq_sequencer instance.
 */
`timescale 1ns/1ps
module psq_seq_monitor #(
    parameter int DEPTH = 1024
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic [31:0]                paddr,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire psq_pkg::psq_dec_type       dec,
    input wire logic                       ext_irq,
    input wire logic                       tmr_irq,
    input wire logic [13:0]                instr_word,
    input wire logic                       exec_valid,
    input wire logic [7:0]                 tbl_data,
    input wire logic                       tbl_data_valid,
    input wire logic [1:0]                 phase
);
    import psq_pkg::*;
    logic xfer;
    logic trd;
    logic mapped;
    logic done;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    assign xfer = phase == 2'h3 && exec_valid &&
        (dec.op inside {OP_JUMP, OP_CALL, OP_RET, OP_PCLWR} ||
         (dec.op == OP_SKIP && dec.skip_true));
    assign trd = phase == 2'h3 && exec_valid &&
        dec.op inside {OP_TRDC, OP_TRDL};
    assign mapped = paddr[9:2] inside {IDX_PCL, IDX_TPTR, IDX_THB,
        IDX_CTRL, IDX_STAT, IDX_TDATA, IDX_PROG};
    assign done = psel && penable && pready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_reset_quiet: assert property ($rose(presetn) |->
        !exec_valid && !pready && phase == 2'h0)
        else $error("outputs busy after reset");
    chk_phase_walk: assert property (phase == 2'h1 |=>
        phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0)
        else $error("phase sequence broken");
    chk_exec_edge: assert property ($changed(instr_word) |->
        $past(phase) == 2'h3)
        else $error("instruction changed off phase three");
    chk_xfer_dummy: assert property (xfer |=>
        !exec_valid [*4] ##1 exec_valid)
        else $error("no single dummy cycle after transfer");
    chk_table_slot: assert property (trd |=>
        !exec_valid [*4] ##1 exec_valid)
        else $error("table read not two cycles");
    chk_table_data: assert property (trd |->
        ##[1:5] tbl_data_valid)
        else $error("table data never delivered");
    chk_tbl_update: assert property ($changed(tbl_data) |->
        tbl_data_valid)
        else $error("table data changed without strobe");
    chk_tbl_pulse: assert property (tbl_data_valid |=>
        !tbl_data_valid)
        else $error("table strobe longer than one cycle");
    chk_apb_answer: assert property (psel && penable && !pready |=>
        pready)
        else $error("register access not answered");
    chk_apb_error: assert property (done |-> pslverr == !mapped)
        else $error("error response wrong");
    // ------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------
    cov_table: cover property (trd ##[1:5] tbl_data_valid);
    cov_skip: cover property (xfer && dec.op == OP_SKIP);
    cov_unmapped: cover property (done && pslverr);
endmodule : psq_seq_monitor

bind psq_sequencer psq_seq_monitor #(.DEPTH(DEPTH)) i_mon (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec(dec),
    .ext_irq(ext_irq), .tmr_irq(tmr_irq), .instr_word(instr_word),
    .exec_valid(exec_valid), .tbl_data(tbl_data),
    .tbl_data_valid(tbl_data_valid), .phase(phase));

//--- tb/tb_program_sequencer_table_read.sv
/*
 * Self-checking bench for the program sequencer and table reads.
 * Assumes the decoder model and the bound port checker.
 */
`timescale 1ns/1ps
module tb_program_sequencer_table_read;
    import psq_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, exec_valid, tbl_data_valid;
    logic        ext_irq = 1'b0, tmr_irq = 1'b0;
    psq_dec_type dec;
    logic [13:0] instr_word;
    logic [7:0]  tbl_data;
    logic [1:0]  phase;
    logic [1:0]  hit = 2'h0;
    logic [13:0] exec_q[$];
    logic [7:0]  tbl_q[$];
    int          err_count = 0, checked = 0, cyc = 0;
    // ------------------------------------------------------------
    // Program image: table ops, a jump, a true skip, vectors
    // ------------------------------------------------------------
    function automatic logic [13:0] rom(input logic [9:0] a);
        case (a)
            10'h000: rom = {3'h6, 11'h000};
            10'h001: rom = {3'h5, 11'h000};
            10'h003: rom = {3'h1, 1'b0, 10'h3FE};
            // Service routines hold no table read
            10'h004: rom = {3'h3, 11'h004};
            10'h008: rom = {3'h3, 11'h008};
            10'h3FE: rom = {3'h4, 1'b1, 10'h000};
            default: rom = {4'h0, a[9:8], a[9:8], a[5:0]};
        endcase
    endfunction : rom
    // Calls, nested to a full stack, then a short jump
    function automatic logic [13:0] prog_b(input logic [9:0] a);
        case (a)
            10'h000: prog_b = {3'h2, 11'h010};
            10'h010: prog_b = {3'h2, 11'h020};
            10'h012: prog_b = {3'h7, 11'h030};
            10'h021: prog_b = {3'h3, 11'h000};
            default: prog_b = rom(a);
        endcase
    endfunction : prog_b
    always #2 pclk = ~pclk;
    psq_sequencer i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec(dec),
        .ext_irq(ext_irq), .tmr_irq(tmr_irq), .instr_word(instr_word),
        .exec_valid(exec_valid), .tbl_data(tbl_data),
        .tbl_data_valid(tbl_data_valid), .phase(phase));
    psq_decoder_model i_dec (.instr_word(instr_word), .dec(dec));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic conclude;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_for(input int lim, input logic [1:0] h, input int q);
        int n;
        n = 0;
        while (!(hit & h) && exec_q.size() < q && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_for
    always @(posedge pclk) begin
        cyc++;
        if (exec_valid === 1'b1 && phase === 2'h3) begin
            exec_q.push_back(instr_word);
            // A dropped prefetch word is no vector hit
            if (instr_word === rom(10'h004)) hit[0] <= 1'b1;
            if (instr_word === rom(10'h008)) hit[1] <= 1'b1;
        end
        if (tbl_data_valid === 1'b1) tbl_q.push_back(tbl_data);
        if (cyc == 40000) begin
            err_count++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] rd;
        logic        er;
        apb(1'b0, IDX_STAT, 32'h0, rd, er);
        check("reset pc", rd & 32'h3FF, 32'h0);
        apb(1'b1, IDX_TPTR, 32'hA5, rd, er);
        apb(1'b0, IDX_TPTR, 32'h0, rd, er);
        check("table_pointer", rd, 32'hA5);
        apb(1'b1, IDX_THB, 32'h3F, rd, er);
        check("high write error", {31'h0, er}, 32'h0);
        apb(1'b0, IDX_THB, 32'h0, rd, er);
        check("table_high_byte", rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0, rd, er);
        check("unmapped error", {31'h0, er}, 32'h1);
        apb(1'b1, IDX_TPTR, 32'h05, rd, er);
        for (int a = 0; a < 1024; a++) begin
            apb(1'b1, IDX_PROG, {18'h0, rom(a[9:0])}, rd, er);
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_run;
        logic [31:0] rd;
        logic        er;
        logic [9:0]  exp_a[6] = '{10'h000, 10'h001, 10'h002,
                                  10'h003, 10'h3FE, 10'h000};
        apb(1'b1, IDX_CTRL, 32'h3, rd, er);
        wait_for(500, 2'h0, 6);
        for (int i = 0; i < 6; i++) begin
            check("exec word", {18'h0, exec_q[i]}, {18'h0, rom(exp_a[i])});
        end
        check("last page low", {24'h0, tbl_q[0]}, 32'hC5);
        check("cur page low", {24'h0, tbl_q[1]}, 32'h05);
        // Read before the next current-page read lands
        while (tbl_q.size() < 3) @(posedge pclk);
        apb(1'b0, IDX_THB, 32'h0, rd, er);
        check("table_high_byte", rd, 32'h3);
        $display("t_run done");
    endtask : t_run
    task automatic t_irq;
        logic [31:0] rd;
        logic        er;
        int          k;
        ext_irq <= 1'b1;
        @(posedge pclk);
        ext_irq <= 1'b0;
        wait_for(400, 2'h1, 100000);
        check("ext vector", {31'h0, hit[0]}, 32'h1);
        apb(1'b1, IDX_CTRL, 32'h5, rd, er);
        exec_q.delete();
        tmr_irq <= 1'b1;
        @(posedge pclk);
        tmr_irq <= 1'b0;
        wait_for(400, 2'h2, 100000);
        check("timer vector", {31'h0, hit[1]}, 32'h1);
        repeat (40) @(posedge pclk);
        k = 0;
        while (k < exec_q.size() - 1 && exec_q[k] !== rom(10'h008)) k++;
        check("return word", {18'h0, exec_q[k+1]}, {18'h0, rom(10'h003)});
        $display("t_irq done");
    endtask : t_irq
    task automatic t_call;
        logic [31:0] rd;
        logic        er;
        logic [9:0]  exp_a[8] = '{10'h000, 10'h010, 10'h020, 10'h021,
                                  10'h011, 10'h004, 10'h012, 10'h030};
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        ext_irq <= 1'b1;
        @(posedge pclk);
        ext_irq <= 1'b0;
        exec_q.delete();
        for (int a = 0; a < 34; a++) begin
            apb(1'b1, IDX_PROG, {18'h0, prog_b(a[9:0])}, rd, er);
        end
        apb(1'b1, IDX_CTRL, 32'h3, rd, er);
        wait_for(300, 2'h0, 8);
        for (int i = 0; i < 7; i++) begin
            rd = {18'h0, prog_b(exp_a[i])};
            check("call order", {18'h0, exec_q[i]}, rd);
        end
        rd = {18'h0, prog_b(exp_a[7])};
        check("short jump", {18'h0, exec_q[7]}, rd);
        $display("t_call done");
    endtask : t_call
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_run();
        t_irq();
        t_call();
        conclude();
    end
endmodule : tb_program_sequencer_table_read
